// file: src/mpt_map.vh
// constants for the match based pwm timer
`ifndef MPT_MAP_VH
`define MPT_MAP_VH
`define MPT_CNT_W        32
`define MPT_NUM_MATCH    7
`define MPT_PERIOD_IDX   0
`define MPT_ACT_W        3
`define MPT_ACT_INT_BIT  0
`define MPT_ACT_RST_BIT  1
`define MPT_ACT_STOP_BIT 2
`define MPT_PCLK_DIV_DEF 2'h0
`define MPT_PCLK_DIV1    2'h1
`define MPT_PCLK_DIV2    2'h2
`define MPT_PCLK_DIV4    2'h0
`endif

// file: src/mpt_clk_div.v
// peripheral clock enable divider from the processor clock
`timescale 1ns/1ns
`default_nettype none
`include "mpt_map.vh"
module mpt_clk_div
(
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire [1:0] div_sel,
	output reg        pclk_en_r
);
	reg  [1:0] cnt_r;
	reg  [1:0] limit;
	always @*
	begin
		if (div_sel == `MPT_PCLK_DIV1)
			limit = 2'h0;
		else if (div_sel == `MPT_PCLK_DIV2)
			limit = 2'h1;
		else
			limit = 2'h3;
	end
	// ============================================================
	// divider, quarter rate after reset
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			cnt_r     <= 2'h0;
			pclk_en_r <= 1'b0;
		end
		else if (cnt_r >= limit)
		begin
			cnt_r     <= 2'h0;
			pclk_en_r <= 1'b1;
		end
		else
		begin
			cnt_r     <= cnt_r + 2'h1;
			pclk_en_r <= 1'b0;
		end
	end
endmodule // mpt_clk_div
`default_nettype wire

// file: src/mpt_pwm_timer.v
// match based pwm timer top
// Operation
// - 32-bit counter advanced by peripheral clock through programmable 32-bit prescaler.
// - seven match registers compared to counter drive actions and pwm edges.
// - a match may let the counter continue, optional interrupt.
// - a match may stop the counter, optional interrupt.
// - a match may clear the counter, optional interrupt.
// - in pwm mode period match resets the counter; all outputs share that rate.
// - single-edge output uses one match register for its falling edge.
// - single-edge outputs rise on period match unless constantly low.
// - double-edge output: one match rises, one falls; either order.
// - up to six single-edge, three double-edge, or a mix.
// - period and widths are any whole number of counts.
// - new match values act only after release; in pwm mode only at cycle start.
// - without pwm enable the block is a plain match timer.
// - peripheral clock divided from processor clock, quarter rate after reset.
`timescale 1ns/1ns
`default_nettype none
`include "mpt_map.vh"
module mpt_pwm_timer
#(
	parameter CW = `MPT_CNT_W,
	parameter NM = `MPT_NUM_MATCH
)
(
	input  wire                   clk_sys,
	input  wire                   rst_n,
	input  wire [1:0]             pclk_div_sel,
	input  wire                   cnt_enable,
	input  wire                   cnt_reset,
	input  wire                   pwm_enable,
	input  wire [CW-1:0]          prescale_limit,
	input  wire [NM*CW-1:0]       match_value,
	input  wire [NM*3-1:0]        match_action,
	input  wire [NM-1:0]          match_release,
	input  wire [NM-1:0]          pwm_out_enable,
	input  wire [NM-1:0]          pwm_double_sel,
	input  wire [NM-1:0]          match_flag_clear,
	output reg  [CW-1:0]          count_r,
	output reg  [CW-1:0]          prescale_count_r,
	output reg  [NM-1:0]          match_flag_r,
	output reg                    int_r,
	output reg                    cnt_running_r,
	output reg  [NM-1:0]          pwm_out_r
);
	// ============================================================
	// shadow and live match values
	reg  [CW-1:0] shadow_r [0:NM-1];
	reg  [CW-1:0] live_r   [0:NM-1];
	reg  [NM-1:0] pending_r;
	wire          pclk_en;
	reg  [NM-1:0] hit;
	reg           tick;
	reg           do_rst;
	reg           do_stop;
	reg  [NM-1:0] pwm_nxt;
	reg           stop_hold_r;
	integer       i;
	integer       j;
	integer       m;

	mpt_clk_div u_div
	(
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.div_sel   (pclk_div_sel),
		.pclk_en_r (pclk_en)
	);

	// ============================================================
	// helper functions
	function [CW-1:0] inc;
		input [CW-1:0] v;
		begin
			inc = v + {{(CW-1){1'b0}}, 1'b1};
		end
	endfunction

	function act_bit;
		input [NM*3-1:0] act;
		input integer    idx;
		input integer    bitn;
		begin
			act_bit = act[idx*3+bitn];
		end
	endfunction

	// ============================================================
	// match compare and counter actions
	always @*
	begin
		tick    = pclk_en && cnt_running_r && (prescale_count_r >= prescale_limit);
		do_rst  = 1'b0;
		do_stop = 1'b0;
		// hits only on a tick, so a halted counter raises no new flags
		for (i = 0; i < NM; i = i + 1)
		begin
			hit[i] = tick && (count_r == live_r[i]);
			// continue is the default when neither reset nor stop is set
			if (hit[i] && act_bit(match_action, i, `MPT_ACT_RST_BIT))
				do_rst = 1'b1;
			if (hit[i] && act_bit(match_action, i, `MPT_ACT_STOP_BIT))
				do_stop = 1'b1;
		end
		// in pwm mode the period register always wraps the cycle
		if (pwm_enable && hit[`MPT_PERIOD_IDX])
			do_rst = 1'b1;
	end

	// ============================================================
	// pwm edges; double output n uses match n-1 to rise and n to fall
	always @*
	begin
		pwm_nxt = pwm_out_r;
		for (j = 1; j < NM; j = j + 1)
		begin
			if (!pwm_enable || !pwm_out_enable[j])
				pwm_nxt[j] = 1'b0;
			else if (pwm_double_sel[j])
			begin
				// fall wins on a tie so equal edges give a low output
				if (hit[j])
					pwm_nxt[j] = 1'b0;
				else if (hit[j-1])
					pwm_nxt[j] = 1'b1;
			end
			else
			begin
				// a falling match of zero keeps the output constantly low
				if (hit[j])
					pwm_nxt[j] = 1'b0;
				else if (hit[`MPT_PERIOD_IDX] && live_r[j] != {CW{1'b0}})
					pwm_nxt[j] = 1'b1;
			end
		end
		pwm_nxt[0] = 1'b0;
	end

	// ============================================================
	// registers
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			count_r          <= {CW{1'b0}};
			prescale_count_r <= {CW{1'b0}};
			match_flag_r     <= {NM{1'b0}};
			int_r            <= 1'b0;
			cnt_running_r    <= 1'b0;
			pwm_out_r        <= {NM{1'b0}};
			pending_r        <= {NM{1'b0}};
			stop_hold_r      <= 1'b0;
			for (m = 0; m < NM; m = m + 1)
			begin
				shadow_r[m] <= {CW{1'b0}};
				live_r[m]   <= {CW{1'b0}};
			end
		end
		else
		begin
			// clear beats a tick so software always reads a clean zero
			if (cnt_reset)
			begin
				count_r          <= {CW{1'b0}};
				prescale_count_r <= {CW{1'b0}};
			end
			else if (pclk_en && cnt_running_r)
			begin
				if (tick)
				begin
					prescale_count_r <= {CW{1'b0}};
					if (do_rst)
						count_r <= {CW{1'b0}};
					else
						count_r <= inc(count_r);
				end
				else
					prescale_count_r <= inc(prescale_count_r);
			end
			// stop latches until the enable drops, else it would only pause a tick
			if (!cnt_enable)
				stop_hold_r <= 1'b0;
			else if (do_stop)
				stop_hold_r <= 1'b1;
			if (do_stop || stop_hold_r)
				cnt_running_r <= 1'b0;
			else
				cnt_running_r <= cnt_enable;
			// set wins over clear; every match flag is sticky
			match_flag_r <= (match_flag_r & ~match_flag_clear) | hit;
			int_r <= |(((match_flag_r & ~match_flag_clear) | hit) & intmask(match_action));
			pwm_out_r <= pwm_nxt;
			for (m = 0; m < NM; m = m + 1)
			begin
				// released value waits for the cycle start in pwm mode, so no runt pulse
				if (match_release[m])
				begin
					shadow_r[m]  <= match_value[m*CW +: CW];
					pending_r[m] <= 1'b1;
				end
				else if (pending_r[m] && (!pwm_enable || do_rst))
				begin
					live_r[m]    <= shadow_r[m];
					pending_r[m] <= 1'b0;
				end
			end
		end
	end

	// ============================================================
	// interrupt enables gathered from the action fields
	function [NM-1:0] intmask;
		input [NM*3-1:0] act;
		integer k;
		begin
			for (k = 0; k < NM; k = k + 1)
				intmask[k] = act[k*3+`MPT_ACT_INT_BIT];
		end
	endfunction
endmodule // mpt_pwm_timer
`default_nettype wire

// file: verification/mpt_props.sv
// checker for the match based pwm timer ports
`timescale 1ns/1ns
`default_nettype none
module mpt_props
#(
	parameter CW = 32,
	parameter NM = 7
)
(
	input wire logic          clk_sys,
	input wire logic          rst_n,
	input wire logic [1:0]    pclk_div_sel,
	input wire logic          cnt_enable,
	input wire logic          cnt_reset,
	input wire logic          pwm_enable,
	input wire logic [NM-1:0] match_flag_clear,
	input wire logic [CW-1:0] count_r,
	input wire logic [NM-1:0] match_flag_r,
	input wire logic          int_r,
	input wire logic          cnt_running_r,
	input wire logic [NM-1:0] pwm_out_r
);
	// ==========
	// assertions
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// zero allowed: a period match or cnt_reset may land inside the gap
	sequence s_hold3;
		($stable(count_r) || count_r == 0)[*3];
	endsequence
	tick_gap_a: assert property (pclk_div_sel == 2'h0 && $changed(count_r) |=> s_hold3)
		else $error("count moved twice within one peripheral clock");
	count_step_a: assert property ($changed(count_r) |-> count_r == $past(count_r) + 1 || count_r == 0)
		else $error("count jumped");
	reset_zero_a: assert property (cnt_reset |=> count_r == 0)
		else $error("count not held at zero");
	pwm_off_a: assert property (!pwm_enable [*2] |-> pwm_out_r == 0)
		else $error("pwm output high in timer mode");
	out_zero_a: assert property (pwm_out_r[0] == 1'b0)
		else $error("output zero driven");
	flag_sticky_a: assert property (|($past(match_flag_r) & ~match_flag_r & ~$past(match_flag_clear)) == 1'b0)
		else $error("flag dropped without clear");
	run_follow_a: assert property (!cnt_enable |=> !cnt_running_r)
		else $error("running without enable");
	int_cause_a: assert property (int_r |-> |($past(match_flag_r) | match_flag_r))
		else $error("interrupt without flag");
	stop_hold_a: assert property ($fell(cnt_running_r) && $past(cnt_enable) && cnt_enable
		|=> !cnt_running_r)
		else $error("counter resumed after stop");
endmodule // mpt_props
bind mpt_pwm_timer mpt_props #(.CW(CW), .NM(NM)) u_props (.clk_sys, .rst_n, .pclk_div_sel,
	.cnt_enable, .cnt_reset, .pwm_enable, .match_flag_clear, .count_r, .match_flag_r, .int_r,
	.cnt_running_r, .pwm_out_r);
`default_nettype wire

// file: verification/mpt_load.sv
// load model measuring pulse high time and period
`timescale 1ns/1ns
`default_nettype none
module mpt_load
(
	input wire logic         clk_sys,
	input wire logic         pin,
	output var logic [15:0]  hi_len,
	output var logic [15:0]  per_len
);
	logic [15:0] hi_r = 16'h0;
	logic [15:0] since_r = 16'h0;
	logic        pin_r = 1'b0;
	// ==========
	// measure in system clocks, the load has no notion of ticks
	always @(posedge clk_sys)
	begin
		pin_r <= pin;
		since_r <= (pin && !pin_r) ? 16'h1 : since_r + 16'h1;
		if (pin && !pin_r)
			per_len <= since_r;
		hi_r <= pin ? hi_r + 16'h1 : 16'h0;
		if (!pin && hi_r != 16'h0)
			hi_len <= hi_r;
	end
endmodule // mpt_load
`default_nettype wire

// file: verification/mpt_pwm_timer_tb_top.sv
// self-checking bench for the match based pwm timer
`timescale 1ns/1ns
`default_nettype none
module mpt_pwm_timer_tb_top;
	logic         clk_sys, rst_n, cnt_enable, cnt_reset, pwm_enable;
	logic [1:0]   pclk_div_sel;
	logic [31:0]  prescale_limit;
	logic [223:0] match_value;
	logic [20:0]  match_action;
	logic [6:0]   match_release, pwm_out_enable, pwm_double_sel, match_flag_clear;
	wire  [31:0]  count_r, prescale_count_r;
	wire  [6:0]   match_flag_r, pwm_out_r;
	wire          int_r, cnt_running_r;
	wire  [15:0]  hi1, per1, hi3;
	int           bad_count = 0;
	int           n_checks = 0;
	int           cyc = 0;
	mpt_pwm_timer uut (.clk_sys, .rst_n, .pclk_div_sel, .cnt_enable, .cnt_reset, .pwm_enable,
		.prescale_limit, .match_value, .match_action, .match_release, .pwm_out_enable,
		.pwm_double_sel, .match_flag_clear, .count_r, .prescale_count_r, .match_flag_r,
		.int_r, .cnt_running_r, .pwm_out_r);
	mpt_load u_load1 (.clk_sys, .pin(pwm_out_r[1]), .hi_len(hi1), .per_len(per1));
	mpt_load u_load3 (.clk_sys, .pin(pwm_out_r[3]), .hi_len(hi3), .per_len());
	// ==========
	// helpers
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic run(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic rel(input logic [6:0] m);
		@(posedge clk_sys);
		match_release <= m;
		@(posedge clk_sys);
		match_release <= 7'h00;
	endtask
	task automatic tally_and_finish;
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_prescale;
		logic [31:0] c;
		@(posedge clk_sys);
		prescale_limit <= 32'h2;
		cnt_enable <= 1'b1;
		run(40);
		c = count_r;
		while (count_r == c) run(1);
		chk("prescale", 32'h0, prescale_count_r);
		c = count_r;
		run(24);
		chk("count", c + 32'h2, count_r);
		run(4);
		chk("prescale", 32'h1, prescale_count_r);
		@(posedge clk_sys);
		cnt_enable <= 1'b0;
		cnt_reset <= 1'b1;
		run(4);
		chk("count", 32'h0, count_r);
		@(posedge clk_sys);
		pclk_div_sel <= 2'h2;
		prescale_limit <= 32'h0;
		cnt_reset <= 1'b0;
		cnt_enable <= 1'b1;
		run(8);
		c = count_r;
		while (count_r == c) run(1);
		c = count_r;
		run(6);
		chk("half rate", c + 32'h3, count_r);
		@(posedge clk_sys);
		cnt_enable <= 1'b0;
		cnt_reset <= 1'b1;
		run(4);
	endtask
	task automatic t_pwm;
		logic [15:0] h;
		@(posedge clk_sys);
		pclk_div_sel <= 2'h1;
		prescale_limit <= 32'h0;
		cnt_reset <= 1'b0;
		pwm_enable <= 1'b1;
		pwm_out_enable <= 7'h0A;
		pwm_double_sel <= 7'h08;
		match_value[127:0] <= {32'h6, 32'h2, 32'h4, 32'h9};
		cnt_enable <= 1'b1;
		rel(7'h0F);
		run(60);
		chk("period", 32'hA, per1);
		chk("double", 32'h4, hi3);
		h = hi1;
		@(posedge clk_sys);
		match_value[63:32] <= 32'h7;
		run(40);
		chk("held", h, hi1);
		rel(7'h02);
		run(40);
		chk("width", h + 32'h3, hi1);
		@(posedge clk_sys);
		match_value[127:64] <= {32'h2, 32'h6};
		rel(7'h0C);
		run(40);
		chk("negative", 32'h6, hi3);
	endtask
	task automatic t_stop;
		logic [31:0] c;
		@(posedge clk_sys);
		pwm_enable <= 1'b0;
		cnt_enable <= 1'b0;
		cnt_reset <= 1'b1;
		match_flag_clear <= 7'h7F;
		match_value[159:128] <= 32'h5;
		match_action[14:12] <= 3'h5;
		rel(7'h10);
		match_flag_clear <= 7'h00;
		cnt_reset <= 1'b0;
		cnt_enable <= 1'b1;
		run(20);
		chk("flag", 32'h1, match_flag_r[4]);
		chk("irq", 32'h1, int_r);
		chk("pwm", 32'h0, pwm_out_r);
		chk("running", 32'h0, cnt_running_r);
		c = count_r;
		run(8);
		chk("halted", c, count_r);
		@(posedge clk_sys);
		cnt_enable <= 1'b0;
		match_flag_clear <= 7'h7F;
		@(posedge clk_sys);
		match_flag_clear <= 7'h00;
		run(3);
		chk("irq", 32'h0, int_r);
	endtask
	// ==========
	// clock, timeout, main
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// run needs well under 1000 cycles
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			tally_and_finish;
		end
	end
	initial
	begin
		{rst_n, cnt_enable, cnt_reset, pwm_enable, pclk_div_sel, prescale_limit} = '0;
		{match_value, match_action, match_release} = '0;
		{pwm_out_enable, pwm_double_sel, match_flag_clear} = '0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_prescale;
		t_pwm;
		t_stop;
		tally_and_finish;
	end
endmodule // mpt_pwm_timer_tb_top
`default_nettype wire
